// *** logic/mon_debug_map.vh ***
// Purpose: Shared constants for the monitor-mode debug abort block.
// Assumes: Plain register port, 32-bit words, one clock.
// Notes:   Offsets are word addresses on the register port.
//
// Contract
// - Control bit 4 enables monitor mode
// - Breakpoint gives prefetch abort, watchpoint data abort; code drops the prefetch abort when a data abort fires in the same cycle
// - No data-value or range matching in monitor
// - Match terms limited to listed qualifiers only
// - External break/watch requests ignored in monitor
// - Record monitor abort in status flag
// - Watchpoint register write suppresses matches that cycle
// - Watchpoints compare data address, breakpoints instruction address
// - One further execute cycle before watchpoint response
// - Complete load/store, then data abort
// - Watchpoint link is last unexecuted address plus 4
// - Breakpoint link as ordinary prefetch abort
// - External abort wins; status flag stays clear
// - Status flag is read/write bit 0
`ifndef MON_DEBUG_MAP_VH
`define MON_DEBUG_MAP_VH

`define DBG_CTRL_OFS      4'h0
`define DBG_STAT_OFS      4'h1
`define BKPT_ADDR_OFS     4'h2
`define BKPT_MASK_OFS     4'h3
`define BKPT_CTRL_OFS     4'h4
`define WPT_ADDR_OFS      4'h5
`define WPT_MASK_OFS      4'h6
`define WPT_CTRL_OFS      4'h7
`define CORE_STAT_OFS     4'h8

`define CTRL_MON_EN_BIT   4
`define CTRL_SSTEP_BIT    3
`define CTRL_RESET_VAL    32'h00000000
`define STAT_ABT_BIT      0

// Unit control field positions
`define UC_EN_BIT         0
`define UC_PRIV_CARE_BIT  1
`define UC_PRIV_VAL_BIT   2
`define UC_WR_CARE_BIT    3
`define UC_WR_VAL_BIT     4
`define UC_SIZE_CARE_BIT  5
`define UC_SIZE_LO_BIT    6
`define UC_SIZE_HI_BIT    7
`define UC_EXT_CARE_BIT   8
`define UC_EXT_VAL_BIT    9
`define UC_CHAIN_BIT      10
`define UC_RESET_VAL      11'h000

`define LINK_ADJUST       32'h00000004
`define WPT_EXTRA_CYCLES  1'b1

`endif

// *** logic/match_unit.v ***
// Purpose: One address comparator with qualifier terms.
// Assumes: Control word layout from mon_debug_map.vh.
// Notes:   Compares addresses only; no data or range terms.
`include "mon_debug_map.vh"
module match_unit #(
    parameter AW = 32                      // Address width
) (
    input  wire [AW-1:0] addr_in,          // Access address
    input  wire [AW-1:0] cmp_addr_in,      // Compare value
    input  wire [AW-1:0] cmp_mask_in,      // Ones ignore a bit
    input  wire [10:0]   ctrl_in,          // Unit control word
    input  wire          priv_in,          // Privileged access
    input  wire          write_in,         // Write direction
    input  wire [1:0]    size_in,          // Access size
    input  wire          ext_in,           // External qualifier
    input  wire          chain_in,         // Chained partner hit
    output wire          hit_out           // Combined match
);
    // Per-term qualifier checks
    wire addr_ok  = ((addr_in ^ cmp_addr_in) & ~cmp_mask_in) == {AW{1'b0}};
    wire priv_ok  = ~ctrl_in[`UC_PRIV_CARE_BIT] | (priv_in == ctrl_in[`UC_PRIV_VAL_BIT]);
    wire wr_ok    = ~ctrl_in[`UC_WR_CARE_BIT] | (write_in == ctrl_in[`UC_WR_VAL_BIT]);
    wire size_ok  = ~ctrl_in[`UC_SIZE_CARE_BIT] |
                    (size_in == ctrl_in[`UC_SIZE_HI_BIT:`UC_SIZE_LO_BIT]);
    wire ext_ok   = ~ctrl_in[`UC_EXT_CARE_BIT] | (ext_in == ctrl_in[`UC_EXT_VAL_BIT]);
    wire chain_ok = ~ctrl_in[`UC_CHAIN_BIT] | chain_in;

    // Only listed terms take part
    assign hit_out = ctrl_in[`UC_EN_BIT] & addr_ok & priv_ok & wr_ok &
                     size_ok & ext_ok & chain_ok;
endmodule

// *** logic/pin_sync.v ***
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are levels from outside the clock domain.
// Notes:   First stage is read only by the second.
module pin_sync #(
    parameter W = 1                        // Bus width
) (
    input  wire         clk_in,            // Core clock
    input  wire         reset_n_in,        // Async reset, low
    input  wire [W-1:0] d_in,              // Raw pin levels
    output reg  [W-1:0] q_out              // Synchronised levels
);
    reg [W-1:0] meta_q;                    // First stage

    // Two stages
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q <= {W{1'b0}};
            q_out  <= {W{1'b0}};
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule

// *** logic/monitor_mode_debug_abort.v ***
// Purpose: Monitor-mode breakpoint/watchpoint abort logic.
// Assumes: Core pipeline signals on clk_in; external requests are pins.
// Notes:   Aborts only while monitor enable is set.
`include "mon_debug_map.vh"
module monitor_mode_debug_abort #(
    parameter AW = 32                      // Address width
) (
    input  wire          clk_in,           // Core clock
    input  wire          reset_n_in,       // Async reset, low
    input  wire [3:0]    reg_addr_in,      // Register word address
    input  wire [31:0]   reg_wdata_in,     // Register write data
    input  wire          reg_wr_in,        // Write strobe
    input  wire          reg_rd_in,        // Read strobe
    output reg  [31:0]   reg_rdata_out,    // Read data, next cycle
    input  wire          fetch_valid_in,   // Instruction fetch valid
    input  wire [AW-1:0] fetch_addr_in,    // Instruction address
    input  wire          instr_priv_indicator_in,  // Fetch privileged
    input  wire          instr_set_state_bit_in,   // Fetch state bit
    input  wire          fetch_ext_abort_in,       // External fetch abort
    input  wire          data_valid_in,    // Data access valid
    input  wire [AW-1:0] data_addr_in,     // Data address
    input  wire          data_write_in,    // Data write direction
    input  wire [1:0]    data_access_size_in,      // Data access size
    input  wire          data_priv_indicator_in,   // Data privileged
    input  wire          data_ext_abort_in,        // External data abort
    input  wire [AW-1:0] next_pc_in,       // Last unexecuted instr address
    input  wire          external_watch_qualifier_in, // Pin qualifier
    input  wire          ext_bkpt_req_in,  // Pin external breakpoint
    input  wire          ext_wpt_req_in,   // Pin external watchpoint
    output reg           prefetch_abort_out,  // Prefetch abort pulse
    output reg           data_abort_out,      // Data abort pulse
    output reg  [AW-1:0] abort_link_out,      // Link value for abort
    output wire          halt_req_out,        // Halt request (non-monitor)
    output wire          monitor_abort_flag_out  // Status flag level
);
    ////////////////////////////////////////////////////////////////////
    // Registers
    reg [31:0]   dbg_ctrl_q;               // Debug control
    reg          abt_flag_q;               // Monitor abort status
    reg [AW-1:0] bkpt_addr_q;              // Breakpoint address
    reg [AW-1:0] bkpt_mask_q;              // Breakpoint mask
    reg [10:0]   bkpt_ctrl_q;              // Breakpoint control
    reg [AW-1:0] wpt_addr_q;               // Watchpoint address
    reg [AW-1:0] wpt_mask_q;               // Watchpoint mask
    reg [10:0]   wpt_ctrl_q;               // Watchpoint control
    reg          wpt_pend_q;               // Watchpoint waiting
    reg          wpt_delay_q;              // Extra execute cycle counter
    reg [AW-1:0] wpt_link_q;               // Captured link value
    reg          halt_q;                   // Halt-mode request level

    wire mon_en = dbg_ctrl_q[`CTRL_MON_EN_BIT];

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire [2:0] pins_s;                     // Synced ext qualifier/bkpt/wpt
    pin_sync #(
        .W (3)
    ) u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .d_in       ({external_watch_qualifier_in, ext_bkpt_req_in, ext_wpt_req_in}),
        .q_out      (pins_s)
    );
    wire ext_qual_s = pins_s[2];           // Qualifier
    wire ext_bkpt_s = pins_s[1];           // External breakpoint
    wire ext_wpt_s  = pins_s[0];           // External watchpoint

    ////////////////////////////////////////////////////////////////////
    // Write decode
    function wr_hit;
        input [3:0] a;
        input [3:0] ofs;
        input       wr;
        begin
            wr_hit = wr & (a == ofs);
        end
    endfunction

    wire wr_ctrl  = wr_hit(reg_addr_in, `DBG_CTRL_OFS, reg_wr_in);
    wire wr_stat  = wr_hit(reg_addr_in, `DBG_STAT_OFS, reg_wr_in);
    wire wr_wunit = wr_hit(reg_addr_in, `WPT_ADDR_OFS, reg_wr_in) |
                    wr_hit(reg_addr_in, `WPT_MASK_OFS, reg_wr_in) |
                    wr_hit(reg_addr_in, `WPT_CTRL_OFS, reg_wr_in);

    ////////////////////////////////////////////////////////////////////
    // Comparators
    wire bkpt_raw;                         // Breakpoint comparator
    wire wpt_raw;                          // Watchpoint comparator

    // Breakpoint on instruction address; size term is state bit
    match_unit #(
        .AW (AW)
    ) u_bkpt (
        .addr_in     (fetch_addr_in),
        .cmp_addr_in (bkpt_addr_q),
        .cmp_mask_in (bkpt_mask_q),
        .ctrl_in     (bkpt_ctrl_q),
        .priv_in     (instr_priv_indicator_in),
        .write_in    (1'b0),
        .size_in     ({1'b0, instr_set_state_bit_in}),
        .ext_in      (ext_qual_s),
        .chain_in    (wpt_raw),
        .hit_out     (bkpt_raw)
    );

    // Watchpoint on data address
    match_unit #(
        .AW (AW)
    ) u_wpt (
        .addr_in     (data_addr_in),
        .cmp_addr_in (wpt_addr_q),
        .cmp_mask_in (wpt_mask_q),
        .ctrl_in     (wpt_ctrl_q),
        .priv_in     (data_priv_indicator_in),
        .write_in    (data_write_in),
        .size_in     (data_access_size_in),
        .ext_in      (ext_qual_s),
        .chain_in    (1'b1),
        .hit_out     (wpt_raw)
    );

    // Qualified hits; watch unit suppressed in its update cycle
    wire bkpt_hit = fetch_valid_in & bkpt_raw;
    wire wpt_hit  = data_valid_in & wpt_raw & ~wr_wunit;

    // Monitor-mode aborts; external abort takes priority
    wire mon_pabt = mon_en & bkpt_hit & ~fetch_ext_abort_in;
    wire wpt_fire = wpt_pend_q & (wpt_delay_q == 1'b0);
    wire mon_dabt = mon_en & wpt_fire;

    // Halt path only outside monitor mode; external requests ignored there
    assign halt_req_out = halt_q;
    assign monitor_abort_flag_out = abt_flag_q;

    ////////////////////////////////////////////////////////////////////
    // Register writes
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dbg_ctrl_q  <= `CTRL_RESET_VAL;
            bkpt_addr_q <= {AW{1'b0}};
            bkpt_mask_q <= {AW{1'b0}};
            bkpt_ctrl_q <= `UC_RESET_VAL;
            wpt_addr_q  <= {AW{1'b0}};
            wpt_mask_q  <= {AW{1'b0}};
            wpt_ctrl_q  <= `UC_RESET_VAL;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `DBG_CTRL_OFS:  dbg_ctrl_q  <= reg_wdata_in;
                `BKPT_ADDR_OFS: bkpt_addr_q <= reg_wdata_in[AW-1:0];
                `BKPT_MASK_OFS: bkpt_mask_q <= reg_wdata_in[AW-1:0];
                `BKPT_CTRL_OFS: bkpt_ctrl_q <= reg_wdata_in[10:0];
                `WPT_ADDR_OFS:  wpt_addr_q  <= reg_wdata_in[AW-1:0];
                `WPT_MASK_OFS:  wpt_mask_q  <= reg_wdata_in[AW-1:0];
                `WPT_CTRL_OFS:  wpt_ctrl_q  <= reg_wdata_in[10:0];
                default: begin
                    // Other offsets store nothing here
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Monitor abort status flag: set wins over software write
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            abt_flag_q <= 1'b0;
        end else if (mon_pabt | mon_dabt) begin
            abt_flag_q <= 1'b1;
        end else if (wr_stat) begin
            abt_flag_q <= reg_wdata_in[`STAT_ABT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Watchpoint delay: access completes, one more execute cycle
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wpt_pend_q  <= 1'b0;
            wpt_delay_q <= 1'b0;
            wpt_link_q  <= {AW{1'b0}};
        end else if (wpt_pend_q) begin
            if (wpt_delay_q != 1'b0) begin
                wpt_delay_q <= wpt_delay_q - 1'b1;
            end else begin
                wpt_pend_q <= 1'b0;
            end
        end else if (mon_en & wpt_hit & ~data_ext_abort_in) begin
            wpt_pend_q  <= 1'b1;
            wpt_delay_q <= `WPT_EXTRA_CYCLES;
            wpt_link_q  <= next_pc_in + `LINK_ADJUST;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Abort outputs and link
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prefetch_abort_out <= 1'b0;
            data_abort_out     <= 1'b0;
            abort_link_out     <= {AW{1'b0}};
        end else begin
            prefetch_abort_out <= mon_pabt & ~mon_dabt;
            data_abort_out     <= mon_dabt;
            if (mon_dabt) begin
                abort_link_out <= wpt_link_q;
            end else if (mon_pabt) begin
                abort_link_out <= fetch_addr_in + `LINK_ADJUST;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Halt request outside monitor mode only
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            halt_q <= 1'b0;
        end else begin
            halt_q <= ~mon_en & (bkpt_hit | wpt_hit | ext_bkpt_s | ext_wpt_s);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 32'h00000000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `DBG_CTRL_OFS:  reg_rdata_out <= dbg_ctrl_q;
                `DBG_STAT_OFS:  reg_rdata_out <= {31'h00000000, abt_flag_q};
                `BKPT_ADDR_OFS: reg_rdata_out <= bkpt_addr_q;
                `BKPT_MASK_OFS: reg_rdata_out <= bkpt_mask_q;
                `BKPT_CTRL_OFS: reg_rdata_out <= {21'h000000, bkpt_ctrl_q};
                `WPT_ADDR_OFS:  reg_rdata_out <= wpt_addr_q;
                `WPT_MASK_OFS:  reg_rdata_out <= wpt_mask_q;
                `WPT_CTRL_OFS:  reg_rdata_out <= {21'h000000, wpt_ctrl_q};
                `CORE_STAT_OFS: reg_rdata_out <= {29'h00000000, halt_q, wpt_pend_q, mon_en};
                default:        reg_rdata_out <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_out <= 32'h00000000;
        end
    end
endmodule

// *** verif/mon_abort_checker.sv ***
// Purpose: Port-level checks for the monitor debug abort block.
// Assumes: One clock domain, async active-low reset.
// Notes:   Bound from the testbench top file.
module mon_abort_checker #(
    parameter AW = 32                           // Address width
) (
    input wire logic          clk_in,           // Core clock
    input wire logic          reset_n_in,       // Async reset, low
    input wire logic          reg_rd_in,        // Read strobe
    input wire logic [31:0]   reg_rdata_out,    // Read data
    input wire logic          fetch_valid_in,   // Fetch valid
    input wire logic [AW-1:0] fetch_addr_in,    // Fetch address
    input wire logic          fetch_ext_abort_in, // External fetch abort
    input wire logic          data_valid_in,    // Data valid
    input wire logic          data_ext_abort_in, // External data abort
    input wire logic [AW-1:0] next_pc_in,       // Last unexecuted address
    input wire logic          prefetch_abort_out, // Prefetch abort
    input wire logic          data_abort_out,   // Data abort
    input wire logic [AW-1:0] abort_link_out,   // Link value
    input wire logic          monitor_abort_flag_out // Status flag
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Quiet cycles after a data abort
    sequence wpt_gap;
        !data_abort_out [*2];
    endsequence
    // Data access taken three edges back
    sequence wpt_cause;
        $past(data_valid_in, 3) && !$past(data_ext_abort_in, 3);
    endsequence
    bkpt_cause_a: assert property (prefetch_abort_out |-> $past(fetch_valid_in))
        else $error("prefetch abort without fetch");
    ext_wins_a: assert property (fetch_ext_abort_in |=> !prefetch_abort_out)
        else $error("prefetch abort despite external abort");
    bkpt_link_a: assert property (prefetch_abort_out |->
        abort_link_out == $past(fetch_addr_in) + 4)
        else $error("breakpoint link wrong");
    wpt_delay_a: assert property (data_abort_out |-> wpt_cause)
        else $error("data abort at wrong delay");
    wpt_link_a: assert property (data_abort_out |->
        abort_link_out == $past(next_pc_in, 3) + 4)
        else $error("watchpoint link wrong");
    wpt_once_a: assert property (data_abort_out |=> wpt_gap)
        else $error("data abort repeated");
    flag_set_a: assert property (prefetch_abort_out || data_abort_out |->
        monitor_abort_flag_out)
        else $error("status flag not set on abort");
    link_hold_a: assert property (!prefetch_abort_out && !data_abort_out |->
        $stable(abort_link_out))
        else $error("link changed without abort");
    rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside read slot");
endmodule

// *** verif/debug_monitor_model.sv ***
// Purpose: Debugger and abort handler seen from the block.
// Assumes: Handler return address formed on each abort pulse.
// Notes:   Supplies the control word the debugger programs.
module debug_monitor_model #(
    parameter AW = 32                           // Address width
) (
    input  wire logic          clk_in,          // Core clock
    input  wire logic          reset_n_in,      // Async reset, low
    input  wire logic          prefetch_abort_in, // Prefetch abort
    input  wire logic          data_abort_in,   // Data abort
    input  wire logic [AW-1:0] link_in,         // Abort link
    output wire logic [31:0]   ctrl_word_out,   // Debug control value
    output wire logic [AW-1:0] return_pc_out    // Handler return address
);
    logic [AW-1:0] return_pc_q;                 // Last return address
    // Monitor on, single-step off, no halt or vector catch bits
    assign ctrl_word_out = 32'h00000010;
    assign return_pc_out = return_pc_q;
    // Handler returns to link minus four
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            return_pc_q <= '0;
        end else if (prefetch_abort_in || data_abort_in) begin
            return_pc_q <= link_in - 4;
        end
    end
endmodule

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for the monitor debug abort block.
// Assumes: Register port strobes one cycle, read data next cycle.
// Notes:   Each scenario is a task; watchdog ends a hang.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
    logic [3:0]  reg_addr_in = '0;
    logic [31:0] reg_wdata_in = '0, reg_rdata_out, fetch_addr_in = '0, data_addr_in = '0;
    logic [31:0] next_pc_in = '0, abort_link_out, ctrl_word, ret_pc;
    logic fetch_valid_in = 0, fetch_ext_abort_in = 0, data_valid_in = 0, data_write_in = 0;
    logic data_ext_abort_in = 0;
    logic ext_bkpt_req_in = 0, ext_wpt_req_in = 0, prefetch_abort_out, data_abort_out;
    logic halt_req_out, monitor_abort_flag_out;
    int fails = 0, checked = 0;
    always #10 clk_in = ~clk_in;
    monitor_mode_debug_abort monitor_mode_debug_abort_inst (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .fetch_valid_in(fetch_valid_in), .fetch_addr_in(fetch_addr_in),
        .instr_priv_indicator_in(1'b0), .instr_set_state_bit_in(1'b0),
        .fetch_ext_abort_in(fetch_ext_abort_in), .data_valid_in(data_valid_in),
        .data_addr_in(data_addr_in), .data_write_in(data_write_in),
        .data_access_size_in(2'h2), .data_priv_indicator_in(1'b0),
        .data_ext_abort_in(data_ext_abort_in), .next_pc_in(next_pc_in),
        .external_watch_qualifier_in(1'b0), .ext_bkpt_req_in(ext_bkpt_req_in),
        .ext_wpt_req_in(ext_wpt_req_in), .prefetch_abort_out(prefetch_abort_out),
        .data_abort_out(data_abort_out), .abort_link_out(abort_link_out),
        .halt_req_out(halt_req_out), .monitor_abort_flag_out(monitor_abort_flag_out));
    debug_monitor_model debug_monitor_model_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .prefetch_abort_in(prefetch_abort_out), .data_abort_in(data_abort_out),
        .link_in(abort_link_out), .ctrl_word_out(ctrl_word), .return_pc_out(ret_pc));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1; reg_addr_in <= a; reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 0;
    endtask
    // Read, data sampled in the following cycle
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        reg_rd_in <= 1; reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 0;
        #1 check("rdata", reg_rdata_out, exp);
    endtask
    // One fetch cycle, returns just after its take edge
    task automatic fetch(input logic [31:0] a, input logic e);
        @(posedge clk_in);
        fetch_valid_in <= 1; fetch_addr_in <= a; fetch_ext_abort_in <= e;
        @(posedge clk_in);
        fetch_valid_in <= 0; fetch_ext_abort_in <= 0;
        #1;
    endtask
    // One data access, optional watch control rewrite in the same cycle
    task automatic dacc(input logic [31:0] a, pc, input logic u, exp, x);
        @(posedge clk_in);
        data_valid_in <= 1; data_addr_in <= a; next_pc_in <= pc; data_write_in <= ~u;
        data_ext_abort_in <= x;
        if (u) begin
            reg_wr_in <= 1; reg_addr_in <= 4'h7; reg_wdata_in <= 32'h1;
        end
        @(posedge clk_in);
        data_valid_in <= 0; reg_wr_in <= 0; data_ext_abort_in <= 0;
        for (int i = 1; i < 4; i++) begin
            #1 check("dabt", data_abort_out, exp && i == 3);
            if (i < 3) @(posedge clk_in);
        end
        if (exp) check("wlink", abort_link_out, pc + 4);
        @(posedge clk_in);
        #1 if (exp) check("ret", ret_pc, pc);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_bkpt;
        wr(4'h0, ctrl_word); wr(4'h2, 32'h100); wr(4'h3, 32'h0);
        wr(4'h4, 32'h7);
        fetch(32'h100, 0);
        check("pabt", prefetch_abort_out, 0);
        wr(4'h4, 32'h1);
        fetch(32'h108, 0);
        check("pabt", prefetch_abort_out, 0);
        fetch(32'h100, 0);
        check("pabt", prefetch_abort_out, 1);
        check("blink", abort_link_out, 32'h104);
        check("flag", monitor_abort_flag_out, 1);
        rd(4'h1, 32'h1);
        wr(4'h1, 32'h0);
        rd(4'h1, 32'h0);
        fetch(32'h100, 1);
        check("pabt", prefetch_abort_out, 0);
        rd(4'h1, 32'h0);
        $display("done t_bkpt");
    endtask
    task automatic t_wpt;
        wr(4'h7, 32'h0); wr(4'h5, 32'h200); wr(4'h6, 32'h0); wr(4'h7, 32'h1);
        dacc(32'h200, 32'h3c0, 0, 1, 0);
        dacc(32'h200, 32'h400, 1, 0, 0);
        dacc(32'h204, 32'h400, 0, 0, 0);
        wr(4'h1, 32'h0);
        dacc(32'h200, 32'h3c0, 0, 0, 1);
        rd(4'h1, 32'h0);
        $display("done t_wpt");
    endtask
    task automatic t_pins;
        @(posedge clk_in);
        ext_bkpt_req_in <= 1; ext_wpt_req_in <= 1;
        repeat (6) begin
            @(posedge clk_in);
            #1 check("extabt", prefetch_abort_out | data_abort_out | halt_req_out, 0);
        end
        @(posedge clk_in);
        ext_bkpt_req_in <= 0; ext_wpt_req_in <= 0;
        $display("done t_pins");
    endtask
    task automatic t_off;
        wr(4'h0, 32'h0);
        fetch(32'h100, 0);
        check("pabt", prefetch_abort_out, 0);
        check("halt", halt_req_out, 1);
        dacc(32'h200, 32'h3c0, 0, 0, 0);
        $display("done t_off");
    endtask
    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1;
        t_bkpt; t_wpt; t_pins; t_off;
        test_done;
    end
    initial begin
        #200000;
        fails++;
        test_done;
    end
endmodule
bind monitor_mode_debug_abort mon_abort_checker #(.AW(AW)) mon_abort_checker_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .fetch_valid_in(fetch_valid_in),
    .fetch_addr_in(fetch_addr_in), .fetch_ext_abort_in(fetch_ext_abort_in),
    .data_valid_in(data_valid_in), .data_ext_abort_in(data_ext_abort_in),
    .next_pc_in(next_pc_in), .prefetch_abort_out(prefetch_abort_out),
    .data_abort_out(data_abort_out), .abort_link_out(abort_link_out),
    .monitor_abort_flag_out(monitor_abort_flag_out));
